// ---- src/t16w_pkg.sv ----
// constants, register map and mode codes of the 16-bit timer waveform block
package t16w_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTL_A = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTL_B = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CMP_A = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CMP_B = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CAPT = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_PINS = 8'h1C;
  // timer_control_a fields
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int FORCE_A_BIT = 3;
  localparam int FORCE_B_BIT = 2;
  localparam int WAVE_LOW_LSB = 0;
  // timer_control_b fields
  localparam int WAVE_HIGH_LSB = 3;
  // flag register fields (write one to clear)
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_MA_BIT = 1;
  localparam int FLAG_MB_BIT = 2;
  // pin control fields
  localparam int PIN_DIR_A_BIT = 0;
  localparam int PIN_DIR_B_BIT = 1;
  localparam int PIN_PORT_A_BIT = 2;
  localparam int PIN_PORT_B_BIT = 3;
  // wave modes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC_8 = 4'h1;
  localparam logic [3:0] MODE_PC_9 = 4'h2;
  localparam logic [3:0] MODE_PC_10 = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_FAST_8 = 4'h5;
  localparam logic [3:0] MODE_FAST_9 = 4'h6;
  localparam logic [3:0] MODE_FAST_10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAPT = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP = 4'h9;
  localparam logic [3:0] MODE_PC_CAPT = 4'hA;
  localparam logic [3:0] MODE_PC_CMP = 4'hB;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
  localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
  localparam logic [3:0] MODE_FAST_CMP = 4'hF;
  // counter limits
  localparam logic [CNT_W-1:0] TOP_8 = 16'h00FF;
  localparam logic [CNT_W-1:0] TOP_9 = 16'h01FF;
  localparam logic [CNT_W-1:0] TOP_10 = 16'h03FF;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // compare output codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  typedef enum logic [2:0] {
    KIND_PLAIN = 3'b001,
    KIND_FAST = 3'b010,
    KIND_DUAL = 3'b100
  } t16w_kind_t;
endpackage

// ---- src/t16w_top.sv ----
// 16-bit timer waveform mode and compare output control with apb registers
// Operation
// - count only on timer tick, one clock
// - phase-frequency mode loads compares at bottom
// - nonzero output code routes wave to pin
// - pin driver enabled only by direction bit
// - non-pwm codes: off, toggle, clear, set
// - fast pwm: 10 non-inverting, 11 inverting
// - fast pwm code 01 toggles a in 15
// - fast pwm: compare equal top ignores match
// - dual slope: 10 clear up, set down
// - dual slope code 01 toggles a in 9 only
// - force bits act only in non-pwm modes
// - force bit is strobe forcing a match
// - force sets no flag, never clears counter
// - force bits always read as zero
// - mode field spans both control registers
// - normal and clear-on-match top and updates
// - phase correct tops, update top, overflow bottom
// - fast pwm tops, update bottom, overflow top
// - phase-frequency tops; mode 13 reserved
// - match flag sets on tick after equality
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module t16w_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // timer clock enable
  input wire logic i_count_tick,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [t16w_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [t16w_pkg::DATA_W-1:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [t16w_pkg::DATA_W-1:0] o_prdata,
  // waveform pins
  output logic o_wave_out_a,
  output logic o_wave_out_a_oe_n,
  output logic o_wave_out_b,
  output logic o_wave_out_b_oe_n
);
  import t16w_pkg::*;

  // ==========================================================
  // mode decoding
  function automatic t16w_kind_t kind_of(input logic [3:0] m);
    unique case (m)
      MODE_PC_8, MODE_PC_9, MODE_PC_10, MODE_PFC_CAPT, MODE_PFC_CMP, MODE_PC_CAPT,
        MODE_PC_CMP: kind_of = KIND_DUAL;
      MODE_FAST_8, MODE_FAST_9, MODE_FAST_10, MODE_FAST_CAPT,
        MODE_FAST_CMP: kind_of = KIND_FAST;
      default: kind_of = KIND_PLAIN;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] top_of(input logic [3:0] m,
      input logic [CNT_W-1:0] cmp_a, input logic [CNT_W-1:0] capt);
    unique case (m)
      MODE_PC_8, MODE_FAST_8: top_of = TOP_8;
      MODE_PC_9, MODE_FAST_9: top_of = TOP_9;
      MODE_PC_10, MODE_FAST_10: top_of = TOP_10;
      MODE_CTC_CMP, MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP: top_of = cmp_a;
      MODE_CTC_CAPT, MODE_PFC_CAPT, MODE_PC_CAPT, MODE_FAST_CAPT: top_of = capt;
      default: top_of = CNT_MAX;
    endcase
  endfunction

  // effective pin connection; code 01 in pwm kinds only for channel a in some modes
  function automatic logic connected(input logic [3:0] m, input logic [1:0] com,
      input logic is_a);
    if (com == COM_OFF) begin
      connected = 1'b0;
    end else if (com != COM_TOGGLE || kind_of(m) == KIND_PLAIN) begin
      connected = 1'b1;
    end else if (kind_of(m) == KIND_FAST) begin
      connected = is_a && m == MODE_FAST_CMP;
    end else begin
      connected = is_a && (m == MODE_PFC_CMP || m == MODE_FAST_CAPT);
    end
  endfunction

  // next waveform bit of one channel
  function automatic logic next_wave(input logic [3:0] m, input logic [1:0] com,
      input logic is_a, input logic cur, input logic match, input logic bottom,
      input logic down, input logic force_hit, input logic cmp_is_top);
    next_wave = cur;
    if (connected(m, com, is_a)) begin
      unique case (kind_of(m))
        KIND_PLAIN: begin
          if (match || force_hit) begin
            unique case (com)
              COM_TOGGLE: next_wave = ~cur;
              COM_CLEAR: next_wave = 1'b0;
              COM_SET: next_wave = 1'b1;
              default: next_wave = cur;
            endcase
          end
        end
        KIND_FAST: begin
          if (com == COM_TOGGLE) begin
            next_wave = match ? ~cur : cur;
          end else if (bottom) begin
            next_wave = (com == COM_CLEAR);
          end else if (match && !cmp_is_top) begin
            next_wave = (com == COM_SET);
          end
        end
        KIND_DUAL: begin
          if (com == COM_TOGGLE) begin
            next_wave = match ? ~cur : cur;
          end else if (match) begin
            next_wave = (com == COM_SET) ^ down;
          end
        end
      endcase
    end
  endfunction

  // ==========================================================
  // registers
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [3:0] wave_mode_field;
  logic [CNT_W-1:0] counter_value;
  logic count_down;
  logic [CNT_W-1:0] cmp_buf_a;
  logic [CNT_W-1:0] cmp_buf_b;
  logic [CNT_W-1:0] compare_value_a;
  logic [CNT_W-1:0] compare_value_b;
  logic [CNT_W-1:0] capture_value_reg;
  logic overflow_flag;
  logic match_flag_a;
  logic match_flag_b;
  logic dir_a;
  logic dir_b;
  logic port_a;
  logic port_b;
  logic wave_a;
  logic wave_b;

  // ==========================================================
  // apb decode
  logic setup_phase;
  logic wr_en;
  logic addr_ok;
  logic [DATA_W-1:0] next_rdata;
  logic wr_ctl_a;
  logic force_a;
  logic force_b;

  assign setup_phase = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
  assign wr_ctl_a = wr_en && i_paddr == ADDR_CTL_A;

  always_comb begin
    addr_ok = 1'b1;
    next_rdata = '0;
    unique case (i_paddr)
      ADDR_CTL_A: next_rdata[7:0] = {com_a, com_b, 2'b00,
                                     wave_mode_field[1:0]};
      ADDR_CTL_B: next_rdata[WAVE_HIGH_LSB +: 2] = wave_mode_field[3:2];
      ADDR_COUNT: next_rdata[CNT_W-1:0] = counter_value;
      ADDR_CMP_A: next_rdata[CNT_W-1:0] = cmp_buf_a;
      ADDR_CMP_B: next_rdata[CNT_W-1:0] = cmp_buf_b;
      ADDR_CAPT: next_rdata[CNT_W-1:0] = capture_value_reg;
      ADDR_FLAGS: next_rdata[2:0] = {match_flag_b, match_flag_a, overflow_flag};
      ADDR_PINS: next_rdata[3:0] = {port_b, port_a, dir_b, dir_a};
      default: addr_ok = 1'b0;
    endcase
  end

  // zero wait state: pready rises in the access cycle of every transfer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= setup_phase;
      o_pslverr <= setup_phase && !addr_ok;
      o_prdata <= setup_phase && !i_pwrite ? next_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      com_a <= COM_OFF;
      com_b <= COM_OFF;
      wave_mode_field <= MODE_NORMAL;
    end else if (wr_ctl_a) begin
      com_a <= i_pwdata[COM_A_LSB +: 2];
      com_b <= i_pwdata[COM_B_LSB +: 2];
      wave_mode_field[1:0] <= i_pwdata[WAVE_LOW_LSB +: 2];
    end else if (wr_en && i_paddr == ADDR_CTL_B) begin
      wave_mode_field[3:2] <= i_pwdata[WAVE_HIGH_LSB +: 2];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dir_a <= 1'b0;
      dir_b <= 1'b0;
      port_a <= 1'b0;
      port_b <= 1'b0;
      capture_value_reg <= CNT_BOTTOM;
    end else if (wr_en && i_paddr == ADDR_PINS) begin
      dir_a <= i_pwdata[PIN_DIR_A_BIT];
      dir_b <= i_pwdata[PIN_DIR_B_BIT];
      port_a <= i_pwdata[PIN_PORT_A_BIT];
      port_b <= i_pwdata[PIN_PORT_B_BIT];
    end else if (wr_en && i_paddr == ADDR_CAPT) begin
      capture_value_reg <= i_pwdata[CNT_W-1:0];
    end
  end

  // ==========================================================
  // counter
  t16w_kind_t kind;
  logic [CNT_W-1:0] top;
  logic at_top;
  logic at_bottom;
  logic wrap_evt;
  logic bottom_evt;
  logic top_evt;
  logic load_evt;
  logic ovf_evt;
  logic match_a;
  logic match_b;

  assign kind = kind_of(wave_mode_field);
  assign top = top_of(wave_mode_field, compare_value_a, capture_value_reg);
  assign at_top = counter_value >= top;
  assign at_bottom = counter_value == CNT_BOTTOM;
  // fast pwm: the tick that leaves top starts the period at bottom
  assign wrap_evt = i_count_tick && kind == KIND_FAST && at_top;
  assign bottom_evt = i_count_tick && kind == KIND_DUAL && at_bottom && count_down;
  assign top_evt = i_count_tick && kind == KIND_DUAL && at_top && !count_down;
  assign load_evt = (kind == KIND_FAST && wrap_evt) ||
                    (wave_mode_field inside {MODE_PFC_CAPT, MODE_PFC_CMP} && bottom_evt) ||
                    (!(wave_mode_field inside {MODE_PFC_CAPT, MODE_PFC_CMP}) && top_evt);
  assign ovf_evt = i_count_tick && ((kind == KIND_PLAIN && counter_value == CNT_MAX) ||
                   wrap_evt || (kind == KIND_DUAL && at_bottom && count_down));
  assign match_a = i_count_tick && counter_value == compare_value_a;
  assign match_b = i_count_tick && counter_value == compare_value_b;
  // forced matches only outside pwm kinds; never touch counter or flags
  assign force_a = wr_ctl_a && i_pwdata[FORCE_A_BIT] && kind == KIND_PLAIN;
  assign force_b = wr_ctl_a && i_pwdata[FORCE_B_BIT] && kind == KIND_PLAIN;

  // timer tick is an enable, never a clock
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      counter_value <= CNT_BOTTOM;
      count_down <= 1'b0;
    end else if (wr_en && i_paddr == ADDR_COUNT) begin
      counter_value <= i_pwdata[CNT_W-1:0];
    end else if (i_count_tick) begin
      unique case (kind)
        KIND_PLAIN, KIND_FAST: begin
          counter_value <= at_top ? CNT_BOTTOM : counter_value + CNT_ONE;
          count_down <= 1'b0;
        end
        KIND_DUAL: begin
          if (!count_down && at_top) begin
            count_down <= 1'b1;
            counter_value <= counter_value - CNT_ONE;
          end else if (count_down && at_bottom) begin
            count_down <= 1'b0;
            counter_value <= counter_value + CNT_ONE;
          end else begin
            counter_value <= count_down ? counter_value - CNT_ONE : counter_value + CNT_ONE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // compare double buffer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cmp_buf_a <= CNT_BOTTOM;
      cmp_buf_b <= CNT_BOTTOM;
    end else if (wr_en && i_paddr == ADDR_CMP_A) begin
      cmp_buf_a <= i_pwdata[CNT_W-1:0];
    end else if (wr_en && i_paddr == ADDR_CMP_B) begin
      cmp_buf_b <= i_pwdata[CNT_W-1:0];
    end
  end

  // plain kinds update at once, pwm kinds at their load point
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      compare_value_a <= CNT_BOTTOM;
      compare_value_b <= CNT_BOTTOM;
    end else if (kind == KIND_PLAIN) begin
      compare_value_a <= cmp_buf_a;
      compare_value_b <= cmp_buf_b;
    end else if (load_evt) begin
      compare_value_a <= cmp_buf_a;
      compare_value_b <= cmp_buf_b;
    end
  end

  // ==========================================================
  // flags: a set in the clearing cycle wins
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      overflow_flag <= 1'b0;
      match_flag_a <= 1'b0;
      match_flag_b <= 1'b0;
    end else begin
      overflow_flag <= ovf_evt ||
        (overflow_flag && !(wr_en && i_paddr == ADDR_FLAGS && i_pwdata[FLAG_OVF_BIT]));
      match_flag_a <= match_a ||
        (match_flag_a && !(wr_en && i_paddr == ADDR_FLAGS && i_pwdata[FLAG_MA_BIT]));
      match_flag_b <= match_b ||
        (match_flag_b && !(wr_en && i_paddr == ADDR_FLAGS && i_pwdata[FLAG_MB_BIT]));
    end
  end

  // ==========================================================
  // waveform and pins
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
    end else begin
      wave_a <= next_wave(wave_mode_field, com_a, 1'b1, wave_a, match_a, wrap_evt,
                          count_down, force_a, compare_value_a == top);
      wave_b <= next_wave(wave_mode_field, com_b, 1'b0, wave_b, match_b, wrap_evt,
                          count_down, force_b, compare_value_b == top);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_wave_out_a <= 1'b0;
      o_wave_out_b <= 1'b0;
      o_wave_out_a_oe_n <= 1'b1;
      o_wave_out_b_oe_n <= 1'b1;
    end else begin
      o_wave_out_a <= connected(wave_mode_field, com_a, 1'b1) ? wave_a : port_a;
      o_wave_out_b <= connected(wave_mode_field, com_b, 1'b0) ? wave_b : port_b;
      o_wave_out_a_oe_n <= !dir_a;
      o_wave_out_b_oe_n <= !dir_b;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_force_read_zero: assert property (
    setup_phase && !i_pwrite && i_paddr == ADDR_CTL_A |=> o_prdata[3:2] == 2'b00)
    else $error("force bits read nonzero");
  chk_pin_drive_dir: assert property (
    !o_wave_out_a_oe_n |-> $past(dir_a)) else $error("pin a driven without direction");
  chk_match_flag_set: assert property (
    match_a |=> match_flag_a) else $error("match flag a not set");
  chk_force_no_flag: assert property (
    force_a && !i_count_tick && !match_flag_a |=> !match_flag_a)
    else $error("forced match set a flag");
  chk_force_no_clear: assert property (
    force_a && wave_mode_field == MODE_CTC_CMP && !i_count_tick
    |=> counter_value == $past(counter_value)) else $error("forced match cleared counter");
  chk_pwm_ignore_force: assert property (
    wr_ctl_a && i_pwdata[FORCE_A_BIT] && kind != KIND_PLAIN && !i_count_tick
    |=> wave_a == $past(wave_a)) else $error("force acted in pwm mode");
  chk_fast_bottom_set: assert property (
    kind == KIND_FAST && com_a == COM_CLEAR && wrap_evt |=> wave_a)
    else $error("fast pwm bottom did not set output");
  chk_dual_up_clear: assert property (
    kind == KIND_DUAL && com_a == COM_CLEAR && match_a && !count_down |=> !wave_a)
    else $error("dual slope up match did not clear");
  chk_pfc_load_bottom: assert property (
    wave_mode_field == MODE_PFC_CAPT && bottom_evt |=> compare_value_a == $past(cmp_buf_a))
    else $error("compare not loaded at bottom");
  chk_normal_toggle: assert property (
    kind == KIND_PLAIN && com_a == COM_TOGGLE && match_a && !force_a
    |=> wave_a != $past(wave_a)) else $error("normal toggle missing");
  chk_route_pin: assert property (
    wave_mode_field == MODE_NORMAL && com_a == COM_CLEAR |=> o_wave_out_a == $past(wave_a))
    else $error("wave not routed to pin a");

  cov_fast_wrap: cover property (kind == KIND_FAST && wrap_evt && com_a == COM_SET);
  cov_dual_turn: cover property (top_evt ##[1:300] bottom_evt);
  cov_force_ctc: cover property (force_a && wave_mode_field == MODE_CTC_CMP);
  cov_flag_race: cover property (match_a && wr_en && i_paddr == ADDR_FLAGS);
endmodule

// ---- verification/t16w_load.sv ----
// external loads on the two waveform pins of the timer block
`timescale 1ns/1ps
module t16w_load (
  // pin drive from the block
  input wire logic i_wave_a,
  input wire logic i_oe_a_n,
  input wire logic i_wave_b,
  input wire logic i_oe_b_n,
  // resolved pin levels
  output logic o_pin_a,
  output logic o_pin_b
);
  // =========================================
  // pin resolution
  // released pins fall to the pull-down, never keep the last value
  assign o_pin_a = i_oe_a_n ? 1'b0 : i_wave_a;
  assign o_pin_b = i_oe_b_n ? 1'b0 : i_wave_b;
endmodule

// ---- verification/timer16_waveform_mode_control_tb.sv ----
// self-checking bench of the timer waveform block
`timescale 1ns/1ps
module timer16_waveform_mode_control_tb;
  import t16w_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_count_tick = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [DATA_W-1:0] i_pwdata = '0;
  logic o_pready, o_pslverr, o_wave_out_a, o_wave_out_a_oe_n, o_wave_out_b, o_wave_out_b_oe_n;
  logic [DATA_W-1:0] o_prdata;
  logic pin_a, pin_b;
  logic [DATA_W:0] exp_q[$];
  logic [DATA_W:0] note;
  logic [15:0] rnd;
  logic [3:0] md;
  logic [1:0] cat[4] = '{COM_SET, COM_TOGGLE, COM_CLEAR, COM_TOGGLE};
  logic [1:0] cbt[4] = '{COM_TOGGLE, COM_CLEAR, COM_SET, COM_TOGGLE};
  logic [3:0] pt[4] = '{4'b0011, 4'b0000, 4'b0001, 4'b0010};
  logic [3:0] mdt[4] = '{MODE_FAST_8, MODE_PC_8, MODE_FAST_CMP, MODE_PFC_CMP};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 48459;

  always #2.5 i_clock = ~i_clock;

  t16w_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_count_tick(i_count_tick),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .o_wave_out_a(o_wave_out_a), .o_wave_out_a_oe_n(o_wave_out_a_oe_n),
    .o_wave_out_b(o_wave_out_b), .o_wave_out_b_oe_n(o_wave_out_b_oe_n));
  t16w_load load_u (.i_wave_a(o_wave_out_a), .i_oe_a_n(o_wave_out_a_oe_n),
    .i_wave_b(o_wave_out_b), .i_oe_b_n(o_wave_out_b_oe_n), .o_pin_a(pin_a), .o_pin_b(pin_b));

  // =========================================
  // closing report
  task automatic finish_test();
    if (exp_q.size() != 0) bad_count++;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // =========================================
  // read watcher: oldest note against each answered read
  always @(posedge i_clock) begin
    if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
      note = exp_q.pop_front();
      comparisons++;
      if ({o_pslverr, o_prdata} !== note) begin
        bad_count++;
        $display("MISMATCH read 0x%h expected 0x%h seen 0x%h", i_paddr, note,
          {o_pslverr, o_prdata});
      end
    end
  end

  // =========================================
  // bus and stimulus tasks
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
                     input logic [DATA_W-1:0] wd, input logic err);
    if (!wr) exp_q.push_back({err, wd});
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= wr ? wd : 32'h0000_0000;
    @(posedge i_clock);
    i_penable <= 1'b1;
    // no local limit: only the bench timeout may end a stuck transfer
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wd);
    apb(1'b1, addr, wd, 1'b0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] ed);
    apb(1'b0, addr, ed, 1'b0);
  endtask

  task automatic set_ctl(input logic [1:0] ca, input logic [1:0] cb, input logic [3:0] m);
    wr(ADDR_CTL_B, {27'h0, m[3:2], 3'h0});
    wr(ADDR_CTL_A, {24'h0, ca, cb, 2'b00, m[1:0]});
  endtask

  // n single-cycle enables back to back
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clock);
      i_count_tick <= 1'b1;
    end
    @(posedge i_clock);
    i_count_tick <= 1'b0;
  endtask

  // e = {oe_a_n, oe_b_n, pin_a, pin_b}; pins lag the waveform register by one edge
  task automatic chk_pins(input logic [3:0] e);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    comparisons++;
    if ({o_wave_out_a_oe_n, o_wave_out_b_oe_n, pin_a, pin_b} !== e) begin
      bad_count++;
      $display("MISMATCH pins expected %b seen %b", e,
        {o_wave_out_a_oe_n, o_wave_out_b_oe_n, pin_a, pin_b});
    end
  endtask

  // =========================================
  // main sequence
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(ADDR_CTL_A, 32'h0000_0000);
    rd(ADDR_CTL_B, 32'h0000_0000);
    chk_pins(4'b1100);
    for (int m = 0; m < 16; m++) begin
      md = m[3:0];
      set_ctl(COM_OFF, COM_OFF, md);
      rd(ADDR_CTL_A, {30'h0, md[1:0]});
      rd(ADDR_CTL_B, {27'h0, md[3:2], 3'h0});
    end
    apb(1'b0, 8'h40, 32'h0000_0000, 1'b1);
    set_ctl(COM_OFF, COM_OFF, MODE_NORMAL);
    rnd = 16'($random(seed));
    wr(ADDR_COUNT, {16'h0, rnd});
    repeat (5) @(posedge i_clock);
    rd(ADDR_COUNT, {16'h0, rnd});
    // forced matches in clear-on-match mode, counter parked below its top
    wr(ADDR_CMP_A, 32'h0000_0100);
    wr(ADDR_COUNT, 32'h0000_0005);
    wr(ADDR_PINS, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      set_ctl(cat[i], cbt[i], MODE_CTC_CMP);
      wr(ADDR_CTL_A, {24'h0, cat[i], cbt[i], 4'b1100});
      rd(ADDR_CTL_A, {24'h0, cat[i], cbt[i], 4'h0});
      chk_pins(pt[i]);
    end
    rd(ADDR_COUNT, 32'h0000_0005);
    rd(ADDR_FLAGS, 32'h0000_0000);
    set_ctl(COM_OFF, COM_OFF, MODE_NORMAL);
    chk_pins(4'b0000);
    wr(ADDR_PINS, 32'h0000_000C);
    chk_pins(4'b1100);
    wr(ADDR_PINS, 32'h0000_0003);
    // normal mode matches one tick after equality
    set_ctl(COM_CLEAR, COM_SET, MODE_NORMAL);
    wr(ADDR_CMP_A, 32'h0000_0020);
    wr(ADDR_CMP_B, 32'h0000_0020);
    wr(ADDR_COUNT, 32'h0000_001F);
    ticks(1);
    chk_pins(4'b0010);
    rd(ADDR_FLAGS, 32'h0000_0000);
    ticks(1);
    chk_pins(4'b0001);
    rd(ADDR_FLAGS, 32'h0000_0006);
    wr(ADDR_COUNT, 32'h0000_FFFF);
    ticks(1);
    rd(ADDR_FLAGS, 32'h0000_0007);
    // clear-on-match top source per mode; a toggles on both matches, so it ends low
    wr(ADDR_CMP_A, 32'h0000_0030);
    wr(ADDR_CAPT, 32'h0000_0040);
    for (int i = 0; i < 2; i++) begin
      set_ctl(COM_TOGGLE, COM_OFF, i ? MODE_CTC_CAPT : MODE_CTC_CMP);
      wr(ADDR_COUNT, 32'h0000_0030);
      ticks(1);
      rd(ADDR_COUNT, i ? 32'h0000_0031 : 32'h0000_0000);
    end
    // among pwm modes, code 01 connects only channel a, and only in modes 15 and 9
    // ports are high, so a disconnected pin reads 1 and a connected a shows its low wave
    wr(ADDR_PINS, 32'h0000_000F);
    for (int i = 0; i < 4; i++) begin
      set_ctl(COM_TOGGLE, COM_TOGGLE, mdt[i]);
      chk_pins({2'b00, 1'(i < 2), 1'b1});
    end
    wr(ADDR_PINS, 32'h0000_0003);
    set_ctl(COM_SET, COM_SET, MODE_FAST_8);
    // deliberately breaks the zero-force habit to show the strobe is ignored
    wr(ADDR_CTL_A, {24'h0, COM_SET, COM_SET, 4'b1101});
    chk_pins(4'b0001);
    // fast pwm: bottom action on wrap, compares loaded there
    set_ctl(COM_CLEAR, COM_SET, MODE_FAST_8);
    wr(ADDR_CMP_A, 32'h0000_0010);
    wr(ADDR_CMP_B, 32'h0000_0010);
    wr(ADDR_FLAGS, 32'h0000_0007);
    wr(ADDR_COUNT, 32'h0000_00FE);
    ticks(2);
    chk_pins(4'b0010);
    rd(ADDR_FLAGS, 32'h0000_0001);
    ticks(16);
    chk_pins(4'b0010);
    ticks(1);
    chk_pins(4'b0001);
    // phase correct 8-bit: up match, turn at 0xFF, down match
    set_ctl(COM_SET, COM_CLEAR, MODE_PC_8);
    wr(ADDR_COUNT, 32'h0000_0010);
    ticks(1);
    chk_pins(4'b0010);
    ticks(477);
    chk_pins(4'b0010);
    ticks(1);
    chk_pins(4'b0001);
    // phase-frequency correct, still counting down: new compare a only after bottom
    set_ctl(COM_CLEAR, COM_CLEAR, MODE_PFC_CAPT);
    wr(ADDR_CMP_A, 32'h0000_0020);
    wr(ADDR_COUNT, 32'h0000_0011);
    ticks(2);
    chk_pins(4'b0011);
    wr(ADDR_FLAGS, 32'h0000_0007);
    // 16 ticks down to bottom, 31 up to 0x20; an old compare a would clear a at 0x10
    ticks(47);
    chk_pins(4'b0010);
    rd(ADDR_FLAGS, 32'h0000_0005);
    ticks(1);
    chk_pins(4'b0000);
    repeat (2) @(posedge i_clock);
    finish_test();
  end
endmodule
